/* design/uci_channel.sv */
// Purpose: interrupt enable, priority, status and clearing for one channel
// Assumes: fifo datapath, modem and flow engines drive the event ports
// Notes: apb answers with no wait state; read data latched in setup phase
`timescale 1ns/100ps
`default_nettype none
module uci_channel (
  // clock and reset
  input  wire logic                    clock_i,
  input  wire logic                    rst_n_i,
  // apb slave
  input  wire logic                    psel_i,
  input  wire logic                    penable_i,
  input  wire logic                    pwrite_i,
  input  wire logic [uci_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [uci_pkg::DATA_W-1:0] pwdata_i,
  output logic [uci_pkg::DATA_W-1:0]   prdata_o,
  output logic                         pready_o,
  output logic                         pslverr_o,
  // datapath status
  input  wire uci_pkg::uci_rx_t        rx_i,
  input  wire uci_pkg::uci_tx_t        tx_i,
  input  wire logic [7:0]              rx_data_i,
  input  wire logic                    bit_tick_i,
  input  wire logic [3:0]              char_bits_i,
  // modem and flow
  input  wire logic [3:0]              modem_delta_i,
  input  wire logic [3:0]              modem_lines_i,
  input  wire logic                    rts_n_i,
  input  wire logic                    cts_n_i,
  input  wire logic                    auto_rts_i,
  input  wire logic                    auto_cts_i,
  // datapath controls
  output logic                         rx_read_o,
  output logic                         tx_write_o,
  output logic [7:0]                   tx_data_o,
  output logic                         fifo_en_o,
  output logic                         rx_fifo_reset_o,
  output logic [7:2]                   fifo_ctl_o,
  output logic                         sleep_en_o,
  // interrupt
  output logic                         irq_o
);
  logic [7:0] ie_ff;
  logic [7:0] ef_ff;
  logic [7:0] em_ff;
  logic       fen_ff;
  logic [7:2] fctl_ff;
  logic       rxrst_ff;
  logic       ovr_ff;
  logic [2:0] lerr_ff;
  logic [3:0] mdelta_ff;
  logic       tx_pend_ff;
  logic       tx_cond_ff;
  logic       ie_tx_ff;
  logic       to_ff;
  logic [7:0] to_cnt_ff;
  logic       xoff_ff;
  logic       spec_ff;
  logic       flow_ff;
  logic       rts_ff;
  logic       cts_ff;
  logic       irq_ff;
  logic [uci_pkg::DATA_W-1:0] rdata_ff;
  logic       setup;
  logic       acc;
  logic       wr;
  logic       rd;
  logic       mapped;
  logic       rd_hold;
  logic       rd_isr;
  logic       rd_lsr;
  logic       rd_msr;
  logic       wr_thr;
  logic       rx_lvl_hit;
  logic       rx_any;
  logic       tx_cond;
  logic       p_ls;
  logic       p_to;
  logic       p_rx;
  logic       p_tx;
  logic       p_ms;
  logic       p_xo;
  logic       p_fl;
  logic [5:0] code;
  logic [7:0] line_status;
  logic [7:0] interrupt_source;
  logic [7:0] nxt_rdata;
  logic [7:0] to_limit;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  // apb decode
  assign setup = psel_i & ~penable_i;
  assign acc   = psel_i & penable_i;
  assign wr    = acc & pwrite_i;
  assign rd    = acc & ~pwrite_i;
  always_comb begin
    if (hit(paddr_i, uci_pkg::OFS_HOLDING) || hit(paddr_i, uci_pkg::OFS_INT_EN) ||
        hit(paddr_i, uci_pkg::OFS_INT_SRC) || hit(paddr_i, uci_pkg::OFS_ENH_FEAT) ||
        hit(paddr_i, uci_pkg::OFS_EXT_MODEM)) begin
      mapped = 1'b1;
    end else if (hit(paddr_i, uci_pkg::OFS_LINE_STAT) ||
                 hit(paddr_i, uci_pkg::OFS_MODEM_ST)) begin
      mapped = ~pwrite_i;
    end else begin
      mapped = 1'b0;
    end
  end
  assign pready_o  = 1'b1;
  assign pslverr_o = acc & ~mapped;
  assign rd_hold = rd & hit(paddr_i, uci_pkg::OFS_HOLDING);
  assign rd_isr  = rd & hit(paddr_i, uci_pkg::OFS_INT_SRC);
  assign rd_lsr  = rd & hit(paddr_i, uci_pkg::OFS_LINE_STAT);
  assign rd_msr  = rd & hit(paddr_i, uci_pkg::OFS_MODEM_ST);
  assign wr_thr  = wr & hit(paddr_i, uci_pkg::OFS_HOLDING);

  // enable register; upper bits guarded by enhanced bit
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ie_ff <= uci_pkg::IE_RST;
    end else if (wr && hit(paddr_i, uci_pkg::OFS_INT_EN)) begin
      ie_ff[3:0] <= pwdata_i[3:0];
      if (ef_ff[uci_pkg::EF_ENH]) begin
        ie_ff[7:4] <= pwdata_i[7:4];
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ef_ff <= uci_pkg::EF_RST;
      em_ff <= uci_pkg::EM_RST;
    end else begin
      if (wr && hit(paddr_i, uci_pkg::OFS_ENH_FEAT)) begin
        ef_ff <= pwdata_i[7:0];
      end
      if (wr && hit(paddr_i, uci_pkg::OFS_EXT_MODEM)) begin
        em_ff <= pwdata_i[7:0];
      end
    end
  end

  // fifo control; reset pulse lasts one cycle then clears itself
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fen_ff   <= uci_pkg::FC_RST[uci_pkg::FC_EN];
      fctl_ff  <= uci_pkg::FC_RST[7:2];
      rxrst_ff <= 1'b0;
    end else begin
      rxrst_ff <= 1'b0;
      if (wr && hit(paddr_i, uci_pkg::OFS_INT_SRC)) begin
        fen_ff <= pwdata_i[uci_pkg::FC_EN];
        if (pwdata_i[uci_pkg::FC_EN]) begin
          fctl_ff  <= pwdata_i[7:2];
          rxrst_ff <= pwdata_i[uci_pkg::FC_RXR];
        end
      end
    end
  end

  // line status error flags; a new event wins over the read clear
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ovr_ff  <= 1'b0;
      lerr_ff <= 3'h0;
    end else begin
      ovr_ff <= rx_i.overrun | (ovr_ff & ~rd_lsr);
      // errors at readout or at once
      lerr_ff <= (em_ff[uci_pkg::EM_IMM] ? (rx_i.char_in ? rx_i.char_err : 3'h0)
                                         : (rx_any ? rx_i.head_err : 3'h0))
                 | (lerr_ff & {3{~rd_lsr}});
    end
  end

  assign rx_any = rx_i.level != '0;
  assign line_status    = {rx_i.any_err, tx_i.all_empty, tx_i.level == '0, lerr_ff, ovr_ff, rx_any};

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mdelta_ff <= 4'h0;
    end else begin
      mdelta_ff <= modem_delta_i | (mdelta_ff & {4{~rd_msr}});
    end
  end

  assign tx_cond = fen_ff ? (tx_i.level < tx_i.trigger || tx_i.level == '0 ||
                             (tx_i.rs485 && tx_i.all_empty))
                          : tx_i.level == '0;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_cond_ff <= 1'b0;
      ie_tx_ff   <= 1'b0;
      tx_pend_ff <= 1'b0;
    end else begin
      tx_cond_ff <= tx_cond;
      ie_tx_ff   <= ie_ff[uci_pkg::IE_TX];
      // set on empty or late enable
      if (tx_cond && (!tx_cond_ff || !ie_tx_ff)) begin
        tx_pend_ff <= 1'b1;
      end else if (wr_thr || (rd_isr && code == uci_pkg::CODE_TRANSMIT_READY_EVENT)) begin
        tx_pend_ff <= 1'b0;
      end
    end
  end

  assign to_limit = 8'(uci_pkg::TO_CHARS * char_bits_i + uci_pkg::TO_BITS);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      to_cnt_ff <= 8'h00;
      to_ff     <= 1'b0;
    end else begin
      if (rx_i.char_in || rd_hold || !rx_any || !fen_ff) begin
        to_cnt_ff <= 8'h00;
      end else if (bit_tick_i && to_cnt_ff != to_limit) begin
        to_cnt_ff <= to_cnt_ff + 8'h01;
      end
      // timeout set and clear
      // counter still sits at its limit on the read edge: the read must block the set
      if (fen_ff && rx_any && to_cnt_ff == to_limit && !rx_i.char_in && !rd_hold) begin
        to_ff <= 1'b1;
      end else if (rd_hold) begin
        to_ff <= 1'b0;
      end
    end
  end

  // software flow flags
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      xoff_ff <= 1'b0;
      spec_ff <= 1'b0;
    end else begin
      xoff_ff <= rx_i.xoff | (xoff_ff & ~rd_isr & ~rx_i.xon);
      spec_ff <= rx_i.special | (spec_ff & ~rd_isr & ~rx_i.char_in);
    end
  end

  // hardware flow edges
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // idle level of the active-low pins, so leaving reset gives no false edge
      rts_ff  <= 1'b1;
      cts_ff  <= 1'b1;
      flow_ff <= 1'b0;
    end else begin
      rts_ff <= rts_n_i;
      cts_ff <= cts_n_i;
      flow_ff <= (auto_rts_i && ie_ff[uci_pkg::IE_RTS] && rts_n_i && !rts_ff) ||
                 (auto_cts_i && ie_ff[uci_pkg::IE_CTS] && cts_n_i && !cts_ff) ||
                 (flow_ff && !rd_msr);
    end
  end

  assign rx_lvl_hit = fen_ff ? rx_i.level >= rx_i.trigger : rx_any;
  assign p_rx = ie_ff[uci_pkg::IE_RX] & rx_lvl_hit;
  assign p_to = ie_ff[uci_pkg::IE_RX] & to_ff;
  assign p_ls = ie_ff[uci_pkg::IE_LS] & (ovr_ff | (|lerr_ff));
  assign p_tx = ie_ff[uci_pkg::IE_TX] & tx_pend_ff;
  assign p_ms = ie_ff[uci_pkg::IE_MS] & (|mdelta_ff);
  assign p_xo = ie_ff[uci_pkg::IE_XOFF] & (xoff_ff | spec_ff);
  assign p_fl = (ie_ff[uci_pkg::IE_RTS] | ie_ff[uci_pkg::IE_CTS]) & flow_ff;

  always_comb begin
    if (p_ls) begin
      code = uci_pkg::CODE_LS;
    end else if (p_to) begin
      code = uci_pkg::CODE_RXTO;
    end else if (p_rx) begin
      code = uci_pkg::CODE_RECEIVE_READY_EVENT;
    end else if (p_tx) begin
      code = uci_pkg::CODE_TRANSMIT_READY_EVENT;
    end else if (p_ms) begin
      code = uci_pkg::CODE_MS;
    end else if (p_xo) begin
      code = uci_pkg::CODE_XOFF;
    end else if (p_fl) begin
      code = uci_pkg::CODE_FLOW;
    end else begin
      code = uci_pkg::CODE_NONE;
    end
  end

  assign interrupt_source = {fen_ff, fen_ff, code};

  always_comb begin
    if (hit(paddr_i, uci_pkg::OFS_HOLDING)) begin
      nxt_rdata = rx_data_i;
    end else if (hit(paddr_i, uci_pkg::OFS_INT_EN)) begin
      nxt_rdata = ie_ff;
    end else if (hit(paddr_i, uci_pkg::OFS_INT_SRC)) begin
      nxt_rdata = interrupt_source;
    end else if (hit(paddr_i, uci_pkg::OFS_LINE_STAT)) begin
      nxt_rdata = line_status;
    end else if (hit(paddr_i, uci_pkg::OFS_MODEM_ST)) begin
      nxt_rdata = {modem_lines_i, mdelta_ff};
    end else if (hit(paddr_i, uci_pkg::OFS_ENH_FEAT)) begin
      nxt_rdata = ef_ff;
    end else if (hit(paddr_i, uci_pkg::OFS_EXT_MODEM)) begin
      nxt_rdata = em_ff;
    end else begin
      nxt_rdata = 8'h00;
    end
  end

  // read data captured in setup so it stands through the access phase
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= '0;
    end else if (setup && !pwrite_i) begin
      rdata_ff <= {24'h000000, nxt_rdata};
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_data_o <= 8'h00;
    end else if (setup && pwrite_i && hit(paddr_i, uci_pkg::OFS_HOLDING)) begin
      tx_data_o <= pwdata_i[7:0];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= p_ls | p_to | p_rx | p_tx | p_ms | p_xo | p_fl;
    end
  end

  assign prdata_o        = rdata_ff;
  assign irq_o           = irq_ff;
  assign rx_read_o       = rd_hold;
  assign tx_write_o      = wr_thr;
  assign fifo_en_o       = fen_ff;
  assign rx_fifo_reset_o = rxrst_ff;
  assign fifo_ctl_o      = fctl_ff;
  assign sleep_en_o      = ie_ff[4];

  // checks
  AST_RX_LEVEL: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (fen_ff && ie_ff[0] && !p_ls && !to_ff && rx_i.level >= rx_i.trigger) |-> code == 6'h04)
    else $error("receive trigger code missing");
  AST_DATA_READY: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    line_status[0] == (rx_i.level != '0))
    else $error("data ready mismatch");
  AST_IE_GUARD: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !ef_ff[4] |=> ie_ff[7:4] == $past(ie_ff[7:4]))
    else $error("upper enables changed without enhanced bit");
  AST_TX_LATE_EN: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ($rose(ie_ff[1]) && tx_cond && !wr_thr) |=> tx_pend_ff)
    else $error("enable while empty gave no transmit interrupt");
  AST_MODEM: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (ie_ff[3] && modem_delta_i != 4'h0) |=> ##1 irq_o)
    else $error("modem change raised no interrupt");
  AST_PRIO_LS: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    p_ls |-> code == 6'h06)
    else $error("line status not top priority");
  AST_IDLE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    interrupt_source[0] == !(p_ls | p_to | p_rx | p_tx | p_ms | p_xo | p_fl))
    else $error("idle bit wrong");
  AST_FIFO_BITS: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    interrupt_source[7:6] == {2{fifo_en_o}})
    else $error("fifo status bits wrong");
  AST_FIFO_RST: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    rx_fifo_reset_o |=> !rx_fifo_reset_o)
    else $error("fifo reset did not self clear");
  AST_IRQ: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    irq_o == $past(code != 6'h01))
    else $error("interrupt output disagrees with pending state");
  AST_LSR_CLR: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (rd_lsr && !rx_i.overrun) |=> !ovr_ff)
    else $error("line read did not clear overrun");
  COV_TIMEOUT: cover property (@(posedge clock_i) disable iff (!rst_n_i) code == 6'h0C);
  COV_FLOW: cover property (@(posedge clock_i) disable iff (!rst_n_i) code == 6'h20);
  COV_TX_CLR: cover property (@(posedge clock_i) disable iff (!rst_n_i) tx_pend_ff ##1 !tx_pend_ff);
endmodule
`default_nettype wire

/* shared/uci_pkg.sv */
// Purpose: constants and carriers for one uart channel's interrupt logic
// Assumes: apb register access, one clock, fifo datapath outside this block
// Notes: offsets and register placement are local to this block
// Operation
// - fifo mode: receive interrupt follows level at or above trigger
// - data-ready status bit set on character entry, cleared when fifo empties
// - fifo on with enable bits 0-3 clear gives polled mode
// - line status bits report overrun, head errors, transmit empties, any fifo error
// - enable bit 0 gates receive interrupt: holding full or trigger reached
// - enable bit 1 gates transmit interrupt; enabling while empty interrupts at once
// - overrun interrupts at once; other errors at readout or at once if selected
// - enable bit 3 gates modem interrupt from four low change bits
// - enable bits 4-7 writable only with enhanced bit 4 set, reset zero
// - rising rts or cts under auto control raises flow interrupt
// - source read returns highest pending; lower ones stay queued, except xoff and special, which any source read clears
// - receive timeout after four characters plus twelve bits, cleared by holding read
// - transmit interrupt from trigger, empty, or rs485 empty; cleared by read or write
// - line read clears line, receive drains clear data, modem read clears modem and flow
// - xoff clears on source read or xon; special on read or next character
// - codes: line 000110, timeout 001100, data 000100, transmit 000010
// - codes: modem 000000, xoff 010000, flow 100000, none 000001
// - source bit 0 is zero while pending, one when idle and at reset
// - source bit 4 needs enable bit 5; bit 5 needs enable bit 6 or 7
// - source bits 7:6 both one with fifos enabled, zero otherwise
// - fifo control bit 0 enables fifos; other bits ignored unless written with it
// - fifo control bit 1 pulses a receive fifo reset and self-clears
package uci_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int LVL_W  = 7;
  localparam logic [7:0] OFS_HOLDING   = 8'h00;
  localparam logic [7:0] OFS_INT_EN    = 8'h04;
  localparam logic [7:0] OFS_INT_SRC   = 8'h08;
  localparam logic [7:0] OFS_LINE_STAT = 8'h0C;
  localparam logic [7:0] OFS_MODEM_ST  = 8'h10;
  localparam logic [7:0] OFS_ENH_FEAT  = 8'h14;
  localparam logic [7:0] OFS_EXT_MODEM = 8'h18;
  localparam int IE_RX   = 0;
  localparam int IE_TX   = 1;
  localparam int IE_LS   = 2;
  localparam int IE_MS   = 3;
  localparam int IE_XOFF = 5;
  localparam int IE_RTS  = 6;
  localparam int IE_CTS  = 7;
  localparam int EF_ENH  = 4;
  localparam int EM_IMM  = 6;
  localparam int FC_EN   = 0;
  localparam int FC_RXR  = 1;
  localparam logic [7:0] IE_RST = 8'h00;
  localparam logic [7:0] EF_RST = 8'h00;
  localparam logic [7:0] EM_RST = 8'h00;
  localparam logic [7:0] FC_RST = 8'h00;
  localparam logic [5:0] CODE_LS    = 6'h06;
  localparam logic [5:0] CODE_RXTO  = 6'h0C;
  localparam logic [5:0] CODE_RECEIVE_READY_EVENT = 6'h04;
  localparam logic [5:0] CODE_TRANSMIT_READY_EVENT = 6'h02;
  localparam logic [5:0] CODE_MS    = 6'h00;
  localparam logic [5:0] CODE_XOFF  = 6'h10;
  localparam logic [5:0] CODE_FLOW  = 6'h20;
  localparam logic [5:0] CODE_NONE  = 6'h01;
  localparam int TO_CHARS = 4;
  localparam int TO_BITS  = 12;
  typedef struct packed {
    logic [LVL_W-1:0] level;
    logic [LVL_W-1:0] trigger;
    logic             char_in;
    logic             overrun;
    logic [2:0]       char_err;
    logic [2:0]       head_err;
    logic             any_err;
    logic             xoff;
    logic             xon;
    logic             special;
  } uci_rx_t;
  typedef struct packed {
    logic [LVL_W-1:0] level;
    logic [LVL_W-1:0] trigger;
    logic             all_empty;
    logic             rs485;
  } uci_tx_t;
endpackage

/* testbench/uci_channel_tb_top.sv */
// Purpose: self-checking bench for the channel interrupt logic
// Assumes: fifo datapath and modem status are driven by the bench itself
// Notes: one table row per source; priority and clearing cases follow
`timescale 1ns/100ps
`default_nettype none
module uci_channel_tb_top;
  logic             clock_i, rst_n_i, psel, penable, pwrite, pready, pslverr, e;
  logic             bit_tick, rts_n, cts_n, irq, fifo_en, rxrst, sleep_en, rx_rd, tx_wr;
  logic [7:0]       paddr, tx_data;
  logic [31:0]      pwdata, prdata, q;
  logic [3:0]       delta;
  logic [5:0]       fctl;
  uci_pkg::uci_rx_t rx;
  uci_pkg::uci_tx_t tx;
  int               errors = 0;
  int               num_checks = 0;
  int               nrst = 0;
  int               nrd = 0;
  int               ntw = 0;
  // enable value beside the source code it must give
  logic [13:0] rows [8] = '{{8'h04, uci_pkg::CODE_LS}, {8'h01, uci_pkg::CODE_RXTO},
    {8'h01, uci_pkg::CODE_RECEIVE_READY_EVENT}, {8'h02, uci_pkg::CODE_TRANSMIT_READY_EVENT}, {8'h08, uci_pkg::CODE_MS},
    {8'h20, uci_pkg::CODE_XOFF}, {8'h80, uci_pkg::CODE_FLOW}, {8'h40, uci_pkg::CODE_FLOW}};
  uci_channel u_uci_channel (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .rx_i(rx), .tx_i(tx), .rx_data_i(8'hA5),
    .bit_tick_i(bit_tick), .char_bits_i(4'hA), .modem_delta_i(delta),
    .modem_lines_i(4'h0), .rts_n_i(rts_n), .cts_n_i(cts_n), .auto_rts_i(1'b1),
    .auto_cts_i(1'b1), .rx_read_o(rx_rd), .tx_write_o(tx_wr), .tx_data_o(tx_data),
    .fifo_en_o(fifo_en), .rx_fifo_reset_o(rxrst), .fifo_ctl_o(fctl), .sleep_en_o(sleep_en),
    .irq_o(irq));
  uci_host u_uci_host (
    .clock_i(clock_i), .pready_i(pready), .pslverr_i(pslverr), .prdata_i(prdata),
    .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
    .pwdata_o(pwdata));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // counts pulses so a stuck reset shows up as extra counts
  always @(posedge clock_i) if (rxrst === 1'b1) nrst++;
  always @(posedge clock_i) if (rx_rd === 1'b1) nrd++;
  always @(posedge clock_i) if (tx_wr === 1'b1) ntw++;
  task automatic end_of_test();
    if (errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h0, got}, {7'h0, exp});
  endtask
  task automatic xf(input logic w, input logic [7:0] a, input logic [7:0] d);
    u_uci_host.xfer(w, a, {24'h0, d}, q, e);
    if (u_uci_host.hangs != 0) begin
      errors++;
      end_of_test();
    end
  endtask
  task automatic do_reset();
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    rx <= uci_pkg::uci_rx_t'{trigger: 7'h08, default: '0};
    tx <= uci_pkg::uci_tx_t'{trigger: 7'h01, all_empty: 1'b1, default: '0};
    rts_n <= 1'b0;
    cts_n <= 1'b0;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
  endtask
  // raise one source; pulses last a single cycle
  task automatic ev(input int k);
    @(posedge clock_i);
    case (k)
      0: rx.overrun <= 1'b1;
      1: rx <= {7'h01, 7'h08, 12'h800};
      2: rx.level <= 7'h08;
      4: delta <= 4'h1;
      5: rx.xoff <= 1'b1;
      6: cts_n <= 1'b1;
      7: rts_n <= 1'b1;
      default: ;
    endcase
    @(posedge clock_i);
    rx <= {rx.level, rx.trigger, 12'h0};
    delta <= 4'h0;
    if (k == 1) begin
      bit_tick <= 1'b1;
      repeat (60) @(posedge clock_i);
      bit_tick <= 1'b0;
    end
  endtask
  initial begin
    repeat (100000) @(posedge clock_i);
    errors++;
    end_of_test();
  end
  initial begin
    rst_n_i = 1'b0;
    rx = '0;
    tx = '0;
    bit_tick = 1'b0;
    rts_n = 1'b0;
    cts_n = 1'b0;
    delta = 4'h0;
    for (int i = 0; i < 8; i++) begin
      do_reset();
      xf(1'b1, uci_pkg::OFS_ENH_FEAT, 8'h10);
      xf(1'b1, uci_pkg::OFS_INT_SRC, 8'h01);
      xf(1'b1, uci_pkg::OFS_INT_EN, rows[i][13:6]);
      ev(i);
      repeat (2) @(posedge clock_i);
      chk1(irq, 1'b1);
      xf(1'b0, uci_pkg::OFS_INT_SRC, 8'h00);
      chk8(q[7:0], {2'b11, rows[i][5:0]});
      case (i)
        0: xf(1'b0, uci_pkg::OFS_LINE_STAT, 8'h00);
        1: xf(1'b0, uci_pkg::OFS_HOLDING, 8'h00);
        2: rx <= {7'h00, 7'h08, 12'h0};
        3, 5: ;
        default: xf(1'b0, uci_pkg::OFS_MODEM_ST, 8'h00);
      endcase
      if (i == 4) chk8(q[7:0], 8'h01);
      repeat (3) @(posedge clock_i);
      xf(1'b0, uci_pkg::OFS_INT_SRC, 8'h00);
      chk8(q[7:0], 8'hC1);
      chk1(irq, 1'b0);
    end
    do_reset();
    chk1(irq, 1'b0);
    xf(1'b0, uci_pkg::OFS_INT_SRC, 8'h00);
    chk8(q[7:0], 8'h01);
    xf(1'b1, uci_pkg::OFS_INT_EN, 8'hF0);
    xf(1'b0, uci_pkg::OFS_INT_EN, 8'h00);
    chk8(q[7:0], 8'h00);
    xf(1'b1, uci_pkg::OFS_ENH_FEAT, 8'h10);
    xf(1'b1, uci_pkg::OFS_INT_EN, 8'hF0);
    xf(1'b0, uci_pkg::OFS_INT_EN, 8'h00);
    chk8(q[7:0], 8'hF0);
    chk1(sleep_en, 1'b1);
    xf(1'b1, uci_pkg::OFS_INT_EN, 8'h00);
    xf(1'b1, uci_pkg::OFS_INT_SRC, 8'hFE);
    xf(1'b0, uci_pkg::OFS_INT_SRC, 8'h00);
    chk8(q[7:0], 8'h01);
    chk8(nrst[7:0], 8'h00);
    chk8({2'b00, fctl}, 8'h00);
    xf(1'b1, uci_pkg::OFS_INT_SRC, 8'hC3);
    repeat (3) @(posedge clock_i);
    chk8(nrst[7:0], 8'h01);
    chk1(fifo_en, 1'b1);
    chk8({2'b00, fctl}, 8'h30);
    // overrun, head error and trigger reached while still polled
    @(posedge clock_i);
    rx <= {7'h08, 7'h08, 12'h428};
    @(posedge clock_i);
    rx <= {7'h08, 7'h08, 12'h008};
    repeat (3) @(posedge clock_i);
    chk1(irq, 1'b0);
    xf(1'b1, uci_pkg::OFS_INT_EN, 8'h0F);
    repeat (3) @(posedge clock_i);
    xf(1'b0, uci_pkg::OFS_INT_SRC, 8'h00);
    chk8(q[7:0], 8'hC6);
    xf(1'b0, uci_pkg::OFS_LINE_STAT, 8'h00);
    chk8(q[7:0], 8'hEB);
    xf(1'b0, uci_pkg::OFS_LINE_STAT, 8'h00);
    chk8(q[7:0], 8'hE1);
    xf(1'b0, uci_pkg::OFS_INT_SRC, 8'h00);
    chk8(q[7:0], 8'hC4);
    rx <= {7'h07, 7'h08, 12'h008};
    repeat (3) @(posedge clock_i);
    xf(1'b0, uci_pkg::OFS_INT_SRC, 8'h00);
    chk8(q[7:0], 8'hC2);
    xf(1'b0, uci_pkg::OFS_INT_SRC, 8'h00);
    chk8(q[7:0], 8'hC1);
    xf(1'b1, uci_pkg::OFS_INT_EN, 8'h0D);
    xf(1'b1, uci_pkg::OFS_INT_EN, 8'h0F);
    repeat (3) @(posedge clock_i);
    chk1(irq, 1'b1);
    xf(1'b1, uci_pkg::OFS_HOLDING, 8'h3C);
    chk8(tx_data, 8'h3C);
    repeat (3) @(posedge clock_i);
    chk1(irq, 1'b0);
    xf(1'b0, uci_pkg::OFS_HOLDING, 8'h00);
    chk8(q[7:0], 8'hA5);
    // unmapped word answers with an error and zero data
    xf(1'b0, 8'h1C, 8'h00);
    chk8(q[7:0], 8'h00);
    chk1(e, 1'b1);
    // one holding read in the table, one above; one holding write
    chk8(nrd[7:0], 8'h02);
    chk8(ntw[7:0], 8'h01);
    end_of_test();
  end
endmodule
`default_nettype wire

/* testbench/uci_host.sv */
// Purpose: host cpu model, apb master for one channel
// Assumes: one clock; pready sampled at rising edges only
// Notes: waits are bounded, so a stuck slave is counted, not waited out
`timescale 1ns/100ps
`default_nettype none
module uci_host (
  // clock and apb answer
  input  wire logic                       clock_i,
  input  wire logic                       pready_i,
  input  wire logic                       pslverr_i,
  input  wire logic [uci_pkg::DATA_W-1:0] prdata_i,
  // apb request
  output logic                            psel_o,
  output logic                            penable_o,
  output logic                            pwrite_o,
  output logic [uci_pkg::ADDR_W-1:0]      paddr_o,
  output logic [uci_pkg::DATA_W-1:0]      pwdata_o
);
  int hangs = 0;
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = '0;
    pwdata_o = '0;
  end
  // request held unchanged until pready is seen high at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clock_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clock_i);
    penable_o <= 1'b1;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready_i !== 1'b1 && n < 20);
    if (n >= 20) hangs++;
    q = prdata_i;
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask
endmodule
`default_nettype wire
